// ---- core/pseq_map.vh ----
// Constants of the program sequencer and table read block
`ifndef PSEQ_MAP_VH
`define PSEQ_MAP_VH
`define PSEQ_PC_W 11
`define PSEQ_IW 14
`define PSEQ_MEM_WORDS 2048
`define PSEQ_MASK_SMALL 11'h03ff
`define PSEQ_MASK_LARGE 11'h07ff
`define PSEQ_VEC_RESET 11'h0000
`define PSEQ_VEC_EXT 11'h0004
`define PSEQ_VEC_TMR 11'h0008
`define PSEQ_LAST_PAGE 3'h7
`define PSEQ_STACK_SMALL 2
`define PSEQ_STACK_LARGE 4
`define PSEQ_PHASE_LAST 2'h3
`define PSEQ_SFR_PC_LOW 7'h06
`define PSEQ_SFR_THL 7'h08
`define PSEQ_STAT_W 4
`define PSEQ_PROG_HDR_LAST 5'h0c
`define PSEQ_PROG_FRAME_LAST 5'h1a
`define PSEQ_VAR_SMALL 2'h0
`define PSEQ_VAR_MID 2'h1
`define PSEQ_VAR_LARGE 2'h2
`endif

// ---- core/pseq_stack.v ----
// Return-address stack with a fixed number of levels
`timescale 1ns/100ps
`include "pseq_map.vh"
module pseq_stack #(
    parameter DEPTH = 4
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_clr,
    input wire i_push,
    input wire i_pop,
    input wire [10:0] i_data,
    output wire [10:0] o_top,
    output wire o_full
);
    reg [10:0] stk_q [0:3];
    reg [2:0] sp_q;
    wire [2:0] depth_w = DEPTH[2:0];
    wire [2:0] top_idx = (sp_q == 3'h0) ? 3'h0 : sp_q - 3'h1;
    // A push when full overwrites the top level; the oldest address is kept
    wire [2:0] wr_idx = o_full ? depth_w - 3'h1 : sp_q;

    assign o_full = (sp_q == depth_w);
    assign o_top = stk_q[top_idx[1:0]];

    always @(posedge i_sys_clk)
    begin
        if (i_push)
        begin
            stk_q[wr_idx[1:0]] <= i_data;
        end
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sp_q <= 3'h0;
        end
        else if (i_clr)
        begin
            sp_q <= 3'h0;
        end
        else if (i_push && !o_full)
        begin
            sp_q <= sp_q + 3'h1;
        end
        else if (i_pop && sp_q != 3'h0)
        begin
            sp_q <= sp_q - 3'h1;
        end
    end
endmodule

// ---- core/pseq_prog_port.v ----
// Serial in-circuit programming port for program memory and data EEPROM
`timescale 1ns/100ps
`include "pseq_map.vh"
module pseq_prog_port (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_active,
    input wire i_sclk_pin,
    input wire i_sdata_pin_i,
    output reg o_sdata_pin_o,
    output reg o_sdata_pin_oe,
    output reg o_mem_we,
    output reg o_ee_we,
    output reg [10:0] o_addr,
    output reg [13:0] o_wdata,
    input wire [13:0] i_mem_rdata,
    input wire [7:0] i_ee_rdata
);
    reg sclk_q1, sclk_q2, sclk_q3;
    reg sd_q1, sd_q2;
    reg [4:0] cnt_q;
    reg [13:0] sh_q;
    reg [13:0] out_q;
    reg tgt_q, wr_q, load_q;
    wire rise = sclk_q2 & ~sclk_q3;
    wire fall = ~sclk_q2 & sclk_q3;
    wire [13:0] nsh = {sh_q[12:0], sd_q2};
    wire [13:0] rd_word = tgt_q ? {6'h00, i_ee_rdata} : i_mem_rdata;

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_q1 <= 1'b0;
            sclk_q2 <= 1'b0;
            sclk_q3 <= 1'b0;
            sd_q1 <= 1'b0;
            sd_q2 <= 1'b0;
        end
        else
        begin
            sclk_q1 <= i_sclk_pin;
            sclk_q2 <= sclk_q1;
            sclk_q3 <= sclk_q2;
            sd_q1 <= i_sdata_pin_i;
            sd_q2 <= sd_q1;
        end
    end

    // One frame: target, write flag, 11 address bits, then 14 data bits either way
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 5'h00;
            sh_q <= 14'h0000;
            out_q <= 14'h0000;
            tgt_q <= 1'b0;
            wr_q <= 1'b0;
            load_q <= 1'b0;
            o_sdata_pin_o <= 1'b0;
            o_sdata_pin_oe <= 1'b0;
            o_mem_we <= 1'b0;
            o_ee_we <= 1'b0;
            o_addr <= 11'h000;
            o_wdata <= 14'h0000;
        end
        else if (!i_active)
        begin
            cnt_q <= 5'h00;
            load_q <= 1'b0;
            o_sdata_pin_oe <= 1'b0;
            o_mem_we <= 1'b0;
            o_ee_we <= 1'b0;
        end
        else
        begin
            o_mem_we <= 1'b0;
            o_ee_we <= 1'b0;
            load_q <= 1'b0;
            if (rise)
            begin
                sh_q <= nsh;
                cnt_q <= (cnt_q == `PSEQ_PROG_FRAME_LAST) ? 5'h00 : cnt_q + 5'h01;
                if (cnt_q == `PSEQ_PROG_HDR_LAST)
                begin
                    tgt_q <= nsh[12];
                    wr_q <= nsh[11];
                    o_addr <= nsh[10:0];
                    load_q <= ~nsh[11];
                end
                if (cnt_q == `PSEQ_PROG_FRAME_LAST)
                begin
                    o_sdata_pin_oe <= 1'b0;
                    if (wr_q)
                    begin
                        o_wdata <= nsh;
                        o_mem_we <= ~tgt_q;
                        o_ee_we <= tgt_q;
                    end
                end
            end
            else if (fall && !wr_q && cnt_q > `PSEQ_PROG_HDR_LAST + 5'h01)
            begin
                out_q <= {out_q[12:0], 1'b0};
                o_sdata_pin_o <= out_q[12];
            end
            if (load_q)
            begin
                // Read data goes back on the same pin the host drove
                out_q <= rd_word;
                o_sdata_pin_o <= rd_word[13];
                o_sdata_pin_oe <= 1'b1;
            end
        end
    end
endmodule

// ---- core/pseq_core.v ----
// Program sequencer with table read, return stack and programming port
// Overview of operation
// - Small variants use a 10-bit program counter; large variant 11 bits.
// - Return stack holds two levels on the smallest variant, four otherwise.
// - Jump or call loads every counter bit from the instruction address field.
// - Return reloads the counter from the top stack entry.
// - Low-byte write keeps upper counter bits, takes lower eight from data.
// - ALU results with carry or other changes update the status register.
// - Program memory is 14 bits wide, 1K or 2K words, counter addressed.
// - After any reset fetching starts at address 000H.
// - Enabled external interrupt falling input branches to 004H if stack free.
// - Enabled timer overflow interrupt branches to 008H if stack free.
// - Table pointer gives the lower eight bits of every table address.
// - Current-page read uses counter upper bits; last-page read uses all ones.
// - Table read puts low byte into named register, high part into latch.
// - Unimplemented latch bits may hold undefined values after a table read.
// - Table-high latch is read-only; no instruction writes it directly.
// - Every table read takes two instruction cycles.
// - Serial programming of flash and EEPROM over one data and one clock pin.
// - Calls and interrupt acknowledges push the counter; reset empties stack.
// - Full stack keeps interrupt request pending until a return frees a level.
// - Low-byte jumps stay in the 256-word page and insert a dummy cycle.
`timescale 1ns/100ps
`include "pseq_map.vh"
module pseq_core #(
    parameter P_VARIANT = 0
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_reset_pin_n,
    input wire i_prog_sclk_pin,
    input wire i_prog_sdata_pin_i,
    output wire o_prog_sdata_pin_o,
    output wire o_prog_sdata_pin_oe,
    input wire i_ext_int_n_pin,
    input wire i_ext_int_en,
    input wire i_tmr_ovf,
    input wire i_tmr_int_en,
    input wire i_jump,
    input wire i_call,
    input wire i_ret,
    input wire i_return_interrupt,
    input wire i_skip,
    input wire i_tab_rd_cur,
    input wire i_tab_rd_last,
    input wire [7:0] i_tblp,
    input wire i_sfr_we,
    input wire [6:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire i_alu_stat_we,
    input wire [3:0] i_alu_stat,
    output reg [13:0] o_instr,
    output wire o_exec_valid,
    output reg [1:0] o_phase,
    output reg [10:0] o_pc,
    output wire [7:0] o_pc_low_byte,
    output reg o_tab_we,
    output reg [6:0] o_tab_dest,
    output reg [7:0] o_tab_low,
    output reg [5:0] o_table_high_latch,
    output reg [3:0] o_status,
    output reg o_int_ack_ext,
    output reg o_int_ack_tmr,
    output wire o_ext_req,
    output wire o_tmr_req,
    output wire o_ee_we,
    output wire [6:0] o_ee_addr,
    output wire [7:0] o_ee_wdata,
    input wire [7:0] i_ee_rdata
);
    localparam [1:0] VAR = P_VARIANT[1:0];
    localparam DEPTH = (VAR == `PSEQ_VAR_SMALL) ? `PSEQ_STACK_SMALL : `PSEQ_STACK_LARGE;
    localparam [10:0] PC_MASK = (VAR == `PSEQ_VAR_LARGE) ? `PSEQ_MASK_LARGE :
        `PSEQ_MASK_SMALL;

    reg [13:0] mem [0:`PSEQ_MEM_WORDS-1];
    reg rp_q1, rp_q2;
    reg ex_q1, ex_q2, ex_q3;
    reg ir_valid_q;
    reg tab_q;
    reg [10:0] tab_addr_q;
    reg ext_req_q, tmr_req_q;
    reg [10:0] pc_d;
    wire [10:0] stk_top;
    wire stk_full;
    wire pg_we, pg_ee_we;
    wire [10:0] pg_addr;
    wire [13:0] pg_wdata;

    // Core runs only while the reset pin is released; low means programming mode
    wire run = rp_q2;
    wire last = (o_phase == `PSEQ_PHASE_LAST);
    wire cyc_end = last & run;
    wire exec = ir_valid_q & ~tab_q & cyc_end;
    wire do_jmp = exec & (i_jump | i_call);
    wire do_ret = exec & (i_ret | i_return_interrupt);
    wire do_low_wr = exec & i_sfr_we & (i_sfr_addr == `PSEQ_SFR_PC_LOW);
    wire do_tab = exec & (i_tab_rd_cur | i_tab_rd_last);
    wire flow = do_jmp | do_ret | do_low_wr;
    // Interrupts wait for a quiet boundary and a free stack level; a skip
    // edge is no boundary, as the pushed address would be the skipped word
    wire int_ok = cyc_end & ~tab_q & ~do_tab & ~flow & ~(exec & i_skip) & ~stk_full;
    wire take_ext = int_ok & ext_req_q & i_ext_int_en;
    wire take_tmr = int_ok & ~take_ext & tmr_req_q & i_tmr_int_en;
    wire push = (exec & i_call) | take_ext | take_tmr;
    wire ext_fall = ~ex_q2 & ex_q3;
    wire [13:0] fetch_word = mem[o_pc];
    wire [13:0] tab_word = mem[tab_addr_q];
    wire [10:0] tab_addr_d = {(i_tab_rd_last ? `PSEQ_LAST_PAGE : o_pc[10:8]),
        i_tblp} & PC_MASK;

    assign o_exec_valid = ir_valid_q & ~tab_q & run;
    assign o_pc_low_byte = o_pc[7:0];
    assign o_ext_req = ext_req_q;
    assign o_tmr_req = tmr_req_q;
    assign o_ee_we = pg_ee_we;
    assign o_ee_addr = pg_addr[6:0];
    assign o_ee_wdata = pg_wdata[7:0];

    pseq_stack #(
        .DEPTH(DEPTH)
    ) u_stack (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clr(~run),
        .i_push(push),
        .i_pop(do_ret),
        .i_data(o_pc),
        .o_top(stk_top),
        .o_full(stk_full)
    );

    pseq_prog_port u_prog (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_active(~run),
        .i_sclk_pin(i_prog_sclk_pin),
        .i_sdata_pin_i(i_prog_sdata_pin_i),
        .o_sdata_pin_o(o_prog_sdata_pin_o),
        .o_sdata_pin_oe(o_prog_sdata_pin_oe),
        .o_mem_we(pg_we),
        .o_ee_we(pg_ee_we),
        .o_addr(pg_addr),
        .o_wdata(pg_wdata),
        .i_mem_rdata(mem[pg_addr]),
        .i_ee_rdata(i_ee_rdata)
    );

    always @(posedge i_sys_clk)
    begin
        if (pg_we)
        begin
            mem[pg_addr] <= pg_wdata;
        end
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rp_q1 <= 1'b0;
            rp_q2 <= 1'b0;
            ex_q1 <= 1'b1;
            ex_q2 <= 1'b1;
            ex_q3 <= 1'b1;
        end
        else
        begin
            rp_q1 <= i_reset_pin_n;
            rp_q2 <= rp_q1;
            ex_q1 <= i_ext_int_n_pin;
            ex_q2 <= ex_q1;
            ex_q3 <= ex_q2;
        end
    end

    // Next program counter; priority: branch, return, low-byte write, interrupt
    always @*
    begin
        pc_d = o_pc;
        if (cyc_end && !tab_q)
        begin
            pc_d = o_pc + 11'h001;
            if (do_jmp)
            begin
                pc_d = o_instr[10:0];
            end
            else if (do_ret)
            begin
                pc_d = stk_top;
            end
            else if (do_low_wr)
            begin
                pc_d = {o_pc[10:8], i_sfr_wdata};
            end
            else if (take_ext)
            begin
                pc_d = `PSEQ_VEC_EXT;
            end
            else if (take_tmr)
            begin
                pc_d = `PSEQ_VEC_TMR;
            end
        end
        pc_d = pc_d & PC_MASK;
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_phase <= 2'h0;
            o_pc <= `PSEQ_VEC_RESET;
            o_instr <= 14'h0000;
            ir_valid_q <= 1'b0;
            tab_q <= 1'b0;
            tab_addr_q <= 11'h000;
        end
        else if (!run)
        begin
            o_phase <= 2'h0;
            o_pc <= `PSEQ_VEC_RESET;
            ir_valid_q <= 1'b0;
            tab_q <= 1'b0;
        end
        else
        begin
            o_phase <= o_phase + 2'h1;
            o_pc <= pc_d;
            if (cyc_end && !tab_q)
            begin
                o_instr <= fetch_word;
                // A changed flow discards the word already fetched: dummy cycle
                ir_valid_q <= ~(flow | take_ext | take_tmr | (exec & i_skip));
                tab_q <= do_tab;
                if (do_tab)
                begin
                    tab_addr_q <= tab_addr_d;
                end
            end
            else if (cyc_end)
            begin
                tab_q <= 1'b0;
            end
        end
    end

    // Table result lands at the end of the second cycle; the latch has no
    // other write path, so writes to its data address fall away here
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_tab_we <= 1'b0;
            o_tab_dest <= 7'h00;
            o_tab_low <= 8'h00;
            o_table_high_latch <= 6'h00;
        end
        else
        begin
            o_tab_we <= tab_q & cyc_end;
            if (do_tab)
            begin
                o_tab_dest <= o_instr[6:0];
            end
            if (tab_q && cyc_end)
            begin
                o_tab_low <= tab_word[7:0];
                o_table_high_latch <= tab_word[13:8];
            end
        end
    end

    // Request flags: a new event in the acknowledge cycle wins over the clear
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ext_req_q <= 1'b0;
            tmr_req_q <= 1'b0;
            o_int_ack_ext <= 1'b0;
            o_int_ack_tmr <= 1'b0;
            o_status <= 4'h0;
        end
        else if (!run)
        begin
            ext_req_q <= 1'b0;
            tmr_req_q <= 1'b0;
            o_int_ack_ext <= 1'b0;
            o_int_ack_tmr <= 1'b0;
            o_status <= 4'h0;
        end
        else
        begin
            ext_req_q <= ext_fall | (ext_req_q & ~take_ext);
            tmr_req_q <= i_tmr_ovf | (tmr_req_q & ~take_tmr);
            o_int_ack_ext <= take_ext;
            o_int_ack_tmr <= take_tmr;
            if (exec && i_alu_stat_we)
            begin
                o_status <= i_alu_stat;
            end
        end
    end
endmodule

// ---- verification/pseq_core_sva.sv ----
// Port-level assertions for the program sequencer
`timescale 1ns/100ps
`include "pseq_map.vh"
module pseq_core_sva #(
    parameter P_VARIANT = 0
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_reset_pin_n,
    input wire i_jump,
    input wire i_call,
    input wire i_ret,
    input wire i_return_interrupt,
    input wire i_tab_rd_cur,
    input wire i_tab_rd_last,
    input wire i_sfr_we,
    input wire [6:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire i_alu_stat_we,
    input wire [3:0] i_alu_stat,
    input wire [13:0] o_instr,
    input wire o_exec_valid,
    input wire [1:0] o_phase,
    input wire [10:0] o_pc,
    input wire o_tab_we,
    input wire [5:0] o_table_high_latch,
    input wire [3:0] o_status,
    input wire o_int_ack_ext,
    input wire o_int_ack_tmr
);
    wire [10:0] mask = (P_VARIANT == 2) ? `PSEQ_MASK_LARGE : `PSEQ_MASK_SMALL;
    wire [10:0] tgt = o_instr[10:0] & mask;
    wire [2:0] pc_hi = o_pc[10:8];
    wire go = o_exec_valid && (o_phase == `PSEQ_PHASE_LAST);
    wire br = i_jump || i_call;
    wire flow = br || i_ret || i_return_interrupt;
    wire low_wr = go && !flow && i_sfr_we && (i_sfr_addr == `PSEQ_SFR_PC_LOW);
    wire tab = go && !flow && (i_tab_rd_cur || i_tab_rd_last);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    pc_width_a: assert property (P_VARIANT == 2 || !o_pc[10])
        else $error("pc bit 10 set on small variant");
    reset_vec_a: assert property (!i_reset_pin_n [*4] |-> o_pc == `PSEQ_VEC_RESET)
        else $error("pc not at reset vector");
    branch_load_a: assert property (go && br |=> o_pc == $past(tgt) && !o_exec_valid)
        else $error("branch target wrong");
    low_jump_a: assert property (low_wr |=> o_pc == {$past(pc_hi),
        $past(i_sfr_wdata)} && !o_exec_valid)
        else $error("low byte jump wrong");
    ext_vec_a: assert property (o_int_ack_ext |-> o_pc == `PSEQ_VEC_EXT)
        else $error("external vector wrong");
    tmr_vec_a: assert property (o_int_ack_tmr |-> o_pc == `PSEQ_VEC_TMR)
        else $error("timer vector wrong");
    tab_time_a: assert property (tab |=> !o_exec_valid [*4] ##1 o_tab_we)
        else $error("table read timing wrong");
    latch_ro_a: assert property ($changed(o_table_high_latch) |-> o_tab_we)
        else $error("latch changed outside table read");
    status_upd_a: assert property (go && i_alu_stat_we |=> o_status == $past(i_alu_stat))
        else $error("status not updated");
    cover property (go && br);
    cover property (o_int_ack_tmr);
    cover property (o_tab_we);
endmodule
bind pseq_core pseq_core_sva #(.P_VARIANT(P_VARIANT)) u_sva (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_pin_n(i_reset_pin_n), .i_jump(i_jump),
    .i_call(i_call), .i_ret(i_ret), .i_return_interrupt(i_return_interrupt), .i_tab_rd_cur(i_tab_rd_cur),
    .i_tab_rd_last(i_tab_rd_last), .i_sfr_we(i_sfr_we), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_alu_stat_we(i_alu_stat_we), .i_alu_stat(i_alu_stat),
    .o_instr(o_instr), .o_exec_valid(o_exec_valid), .o_phase(o_phase), .o_pc(o_pc),
    .o_tab_we(o_tab_we), .o_table_high_latch(o_table_high_latch), .o_status(o_status),
    .o_int_ack_ext(o_int_ack_ext), .o_int_ack_tmr(o_int_ack_tmr)
);

// ---- verification/pseq_prog_tool.sv ----
// Model of the external programming tool on the serial port and reset pin
`timescale 1ns/100ps
module pseq_prog_tool (
    input wire i_sys_clk,
    input wire i_sdata,
    output logic o_reset_pin_n,
    output logic o_sclk,
    output logic o_sdata,
    output logic o_sdata_oe
);
    initial
    begin
        o_reset_pin_n = 1'b0;
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_sdata_oe = 1'b0;
    end
    // Clock idles low between frames; data changes only while the clock is low
    task automatic frame(input logic tgt, input logic wr, input logic [10:0] addr,
                         input logic [13:0] wdata, output logic [13:0] rdata);
        logic [26:0] bits;
        bits = {tgt, wr, addr, wdata};
        rdata = 14'h0000;
        for (int i = 26; i >= 0; i--)
        begin
            @(posedge i_sys_clk);
            #1;
            o_sdata_oe = wr || (i > 13);
            o_sdata = bits[i];
            repeat (8) @(posedge i_sys_clk);
            #1;
            o_sclk = 1'b1;
            if (i < 14)
                rdata = {rdata[12:0], i_sdata};
            repeat (8) @(posedge i_sys_clk);
            #1;
            o_sclk = 1'b0;
        end
        o_sdata_oe = 1'b0;
    endtask
    task automatic release_reset();
        @(posedge i_sys_clk);
        #1;
        o_reset_pin_n = 1'b1;
    endtask
endmodule

// ---- verification/pseq_core_tb.sv ----
// Self-checking testbench for the program sequencer
`timescale 1ns/100ps
`include "pseq_map.vh"
module pseq_core_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic int_n = 1'b1;
    logic ext_en = 1'b0;
    logic tovf = 1'b0;
    logic tmr_en = 1'b0;
    logic [6:0] ctl = 7'h00;
    logic [7:0] tblp = 8'h00;
    logic sfr_we = 1'b0;
    logic [6:0] sfr_a = 7'h00;
    logic [7:0] sfr_d = 8'h00;
    logic st_we = 1'b0;
    logic [3:0] st = 4'h0;
    logic [13:0] rd;
    logic [15:0] ee_seen = 16'h0000;
    int errors = 0;
    int check_count = 0;
    int n_ext = 0;
    wire rst_n, sclk, t_sd, t_oe, d_sd, d_oe, ev, tab_we, ack_e, ack_t, req_e, req_t, ee_we;
    wire [13:0] instr;
    wire [1:0] ph;
    wire [10:0] pc;
    wire [7:0] tab_low, ee_d, pc_lb;
    wire [5:0] thl;
    wire [3:0] stat;
    wire [6:0] ee_a, tdst;
    // Data pin has a pull-up, so a released line reads high
    wire sd = d_oe ? d_sd : (t_oe ? t_sd : 1'b1);
    always #25 i_sys_clk = ~i_sys_clk;
    pseq_core #(.P_VARIANT(0)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_pin_n(rst_n),
        .i_prog_sclk_pin(sclk), .i_prog_sdata_pin_i(sd), .o_prog_sdata_pin_o(d_sd),
        .o_prog_sdata_pin_oe(d_oe), .i_ext_int_n_pin(int_n), .i_ext_int_en(ext_en),
        .i_tmr_ovf(tovf), .i_tmr_int_en(tmr_en), .i_jump(ctl[6]), .i_call(ctl[5]),
        .i_ret(ctl[4]), .i_return_interrupt(ctl[3]), .i_skip(ctl[2]), .i_tab_rd_cur(ctl[1]),
        .i_tab_rd_last(ctl[0]), .i_tblp(tblp), .i_sfr_we(sfr_we), .i_sfr_addr(sfr_a),
        .i_sfr_wdata(sfr_d), .i_alu_stat_we(st_we), .i_alu_stat(st), .o_instr(instr),
        .o_exec_valid(ev), .o_phase(ph), .o_pc(pc), .o_pc_low_byte(pc_lb), .o_tab_we(tab_we),
        .o_tab_dest(tdst), .o_tab_low(tab_low), .o_table_high_latch(thl), .o_status(stat),
        .o_int_ack_ext(ack_e), .o_int_ack_tmr(ack_t), .o_ext_req(req_e), .o_tmr_req(req_t),
        .o_ee_we(ee_we), .o_ee_addr(ee_a), .o_ee_wdata(ee_d), .i_ee_rdata(8'h5a)
    );
    pseq_prog_tool tool (.i_sys_clk(i_sys_clk), .i_sdata(sd), .o_reset_pin_n(rst_n),
        .o_sclk(sclk), .o_sdata(t_sd), .o_sdata_oe(t_oe));
    always @(posedge i_sys_clk)
    begin
        if (ee_we === 1'b1)
            ee_seen <= {1'b0, ee_a, ee_d};
        if (ack_e === 1'b1)
            n_ext <= n_ext + 1;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic hit(input int w);
        if (w == 0)
            return ev === 1'b1 && ph === `PSEQ_PHASE_LAST;
        return w == 1 ? ack_e === 1'b1 : ack_t === 1'b1;
    endfunction
    // Bounded wait: 0 = execute phase, 1 = external ack, 2 = timer ack
    task automatic wait_for(input int w);
        int n;
        n = 0;
        while (!hit(w) && n < 200)
        begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        cmp({15'h0000, n < 200}, 16'h0001);
    endtask
    // Controls are held through the single edge that closes the execute phase
    task automatic ex(input logic [6:0] c, input logic [6:0] a, input logic [7:0] d);
        wait_for(0);
        ctl = c;
        sfr_we = (a != 7'h00);
        sfr_a = a;
        sfr_d = d;
        @(posedge i_sys_clk);
        #1;
        ctl = 7'h00;
        sfr_we = 1'b0;
    endtask
    task automatic pulse_ext();
        int_n = 1'b0;
        repeat (4) @(posedge i_sys_clk);
        #1;
        int_n = 1'b1;
    endtask
    task automatic pulse_tmr();
        tovf = 1'b1;
        @(posedge i_sys_clk);
        #1;
        tovf = 1'b0;
    endtask
    task automatic t_prog();
        tool.frame(1'b0, 1'b1, 11'h000, 14'h0055, rd);
        tool.frame(1'b0, 1'b1, 11'h0a0, 14'h0011, rd);
        tool.frame(1'b0, 1'b1, 11'h055, 14'h0123, rd);
        tool.frame(1'b0, 1'b1, 11'h3a5, 14'h2b7c, rd);
        tool.frame(1'b0, 1'b0, 11'h3a5, 14'h0000, rd);
        cmp({2'b00, rd}, 16'h2b7c);
        tool.frame(1'b1, 1'b1, 11'h012, 14'h003c, rd);
        repeat (8) @(posedge i_sys_clk);
        cmp(ee_seen, 16'h123c);
    endtask
    task automatic t_flow();
        tool.release_reset();
        wait_for(0);
        cmp({2'b00, instr}, 16'h0055);
        ex(7'h40, 7'h00, 8'h00);
        cmp({5'h00, pc}, 16'h0055);
        cmp({15'h0000, ev}, 16'h0000);
        ex(7'h20, 7'h00, 8'h00);
        cmp({5'h00, pc}, 16'h0123);
        ex(7'h10, 7'h00, 8'h00);
        cmp({5'h00, pc}, 16'h0056);
        ex(7'h04, 7'h00, 8'h00);
        cmp({5'h00, pc}, 16'h0058);
        ex(7'h00, `PSEQ_SFR_PC_LOW, 8'ha0);
        cmp({5'h00, pc}, 16'h00a0);
        cmp({8'h00, pc_lb}, 16'h00a0);
    endtask
    task automatic t_table();
        tblp = 8'ha5;
        ex(7'h01, 7'h00, 8'h00);
        repeat (4) @(posedge i_sys_clk);
        #1;
        cmp({15'h0000, tab_we}, 16'h0001);
        cmp({8'h00, tab_low}, 16'h007c);
        cmp({10'h000, thl}, 16'h002b);
        cmp({9'h000, tdst}, 16'h0011);
        ex(7'h00, `PSEQ_SFR_THL, 8'hff);
        repeat (4) @(posedge i_sys_clk);
        #1;
        cmp({10'h000, thl}, 16'h002b);
        tblp = 8'h55;
        ex(7'h02, 7'h00, 8'h00);
        repeat (4) @(posedge i_sys_clk);
        #1;
        cmp({8'h00, tab_low}, 16'h0023);
        cmp({10'h000, thl}, 16'h0001);
    endtask
    task automatic t_int();
        int k;
        ext_en = 1'b1;
        tmr_en = 1'b1;
        pulse_ext();
        wait_for(1);
        cmp({5'h00, pc}, 16'h0004);
        pulse_tmr();
        wait_for(2);
        cmp({5'h00, pc}, 16'h0008);
        k = n_ext;
        pulse_ext();
        pulse_tmr();
        repeat (40) @(posedge i_sys_clk);
        cmp({15'h0000, req_e}, 16'h0001);
        cmp({15'h0000, req_t}, 16'h0001);
        cmp(16'(n_ext - k), 16'h0000);
        ex(7'h08, 7'h00, 8'h00);
        wait_for(1);
        cmp({5'h00, pc}, 16'h0004);
        cmp({15'h0000, req_t}, 16'h0001);
        ext_en = 1'b0;
        tmr_en = 1'b0;
    endtask
    task automatic t_status();
        wait_for(0);
        st_we = 1'b1;
        st = 4'h9;
        @(posedge i_sys_clk);
        #1;
        st_we = 1'b0;
        cmp({12'h000, stat}, 16'h0009);
    endtask
    task automatic t_rereset();
        i_rst = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        wait_for(0);
        cmp({2'b00, instr}, 16'h0055);
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        t_prog();
        t_flow();
        t_table();
        t_int();
        t_status();
        t_rereset();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        errors++;
        complete_run();
    end
endmodule
